// ===== verif/trx_exec_test.sv
/*
  Self-checking bench for the table-read and XOR execution unit.
  Assumes the unit answers one cycle after taking an op, two for a table read.
*/
`timescale 1ns/10ps
`include "trx_params.svh"

module trx_exec_test
  import trx_pkg::*;
;
  logic clock, arst_n, op_valid, op_dest;
  trx_op_t op_code;
  logic [7:0] op_operand, table_pointer_high, timer0_mode_reg, file_rdata;
  logic [13:0] rom_rdata;
  logic [7:0] working_register_q, table_data_high_q, file_wdata_q;
  logic [10:0] rom_addr_q;
  logic [6:0] file_addr_q;
  logic rom_rd_q, file_we_q, zero_flag_q, zero_update_q;
  int n_errors = 0;
  int checked = 0;

  trx_exec dut_u (.clock(clock), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
    .op_operand(op_operand), .op_dest(op_dest), .table_pointer_high(table_pointer_high),
    .timer0_mode_reg(timer0_mode_reg), .file_rdata(file_rdata), .rom_rdata(rom_rdata),
    .working_register_q(working_register_q), .table_data_high_q(table_data_high_q),
    .rom_addr_q(rom_addr_q), .rom_rd_q(rom_rd_q), .file_addr_q(file_addr_q),
    .file_wdata_q(file_wdata_q), .file_we_q(file_we_q), .zero_flag_q(zero_flag_q),
    .zero_update_q(zero_update_q));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Offers one op, returns just after the taking edge
  task automatic op_go(input trx_op_t c, input logic [7:0] opnd, input logic d);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    op_operand <= opnd;
    op_dest <= d;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask : op_go

  task automatic t_timer;
    timer0_mode_reg <= 8'h34;
    op_go(trx_op_read_timer, 8'h00, 1'b0);
    chk(working_register_q, 16'h0034);
    chk(zero_update_q, 16'h0000);
    $display("test read_timer done");
  endtask : t_timer

  task automatic t_table;
    @(posedge clock);
    table_pointer_high <= 8'hfa;
    rom_rdata <= 14'h35aa;
    op_go(trx_op_table_read, 8'h00, 1'b0);
    chk(rom_rd_q, 16'h0001);
    chk(rom_addr_q, 16'h0234);
    chk(working_register_q, 16'h0034);
    @(posedge clock);
    #1;
    chk(rom_rd_q, 16'h0000);
    chk(working_register_q, 16'h00aa);
    chk(table_data_high_q, 16'h0035);
    chk(zero_update_q, 16'h0000);
    @(posedge clock);
    rom_rdata <= 14'h0a55;
    @(posedge clock);
    #1;
    chk(working_register_q, 16'h00aa);
    chk(table_data_high_q, 16'h0035);
    $display("test table_read done");
  endtask : t_table

  task automatic t_xor_imm;
    op_go(trx_op_xor_imm, 8'haa, 1'b1);
    chk(working_register_q, 16'h0000);
    chk(file_we_q, 16'h0000);
    chk({zero_update_q, zero_flag_q}, 16'h0003);
    op_go(trx_op_xor_imm, 8'h5f, 1'b0);
    chk(working_register_q, 16'h005f);
    chk({zero_update_q, zero_flag_q}, 16'h0002);
    $display("test xor_imm done");
  endtask : t_xor_imm

  task automatic t_xor_file;
    @(posedge clock);
    file_rdata <= 8'ha5;
    op_go(trx_op_xor_file, 8'hff, 1'b1);
    chk(file_we_q, 16'h0001);
    chk(file_addr_q, 16'h007f);
    chk(file_wdata_q, 16'h00fa);
    chk(working_register_q, 16'h005f);
    chk({zero_update_q, zero_flag_q}, 16'h0002);
    @(posedge clock);
    file_rdata <= 8'h5f;
    op_go(trx_op_xor_file, 8'h05, 1'b0);
    chk(file_we_q, 16'h0000);
    chk(working_register_q, 16'h0000);
    chk({zero_update_q, zero_flag_q}, 16'h0003);
    $display("test xor_file done");
  endtask : t_xor_file

  initial begin
    arst_n = 1'b0;
    op_valid = 1'b0;
    op_code = trx_op_none;
    op_operand = 8'h00;
    op_dest = 1'b0;
    table_pointer_high = 8'h00;
    timer0_mode_reg = 8'h00;
    file_rdata = 8'h00;
    rom_rdata = 14'h0000;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    t_timer();
    t_table();
    t_xor_imm();
    t_xor_file();
    end_of_test();
  end

  initial begin
    repeat (200) @(posedge clock);
    n_errors++;
    end_of_test();
  end
endmodule : trx_exec_test

// ===== verilog/trx_exec.sv
/*
  Execution unit for table read, timer-mode read and the two XOR operations.
  Assumes the decoder holds op_* stable with op_valid, supplies file_rdata for the
  addressed register in the same cycle, and that program memory answers rom_rdata
  combinationally for rom_addr while rom_rd is high. Decoder must stall while rom_rd is high.
*/
// Notes on behaviour
// - Table read addresses ROM by pointer and accumulator
// - Upper six ROM bits go to table-data-high
// - Table read takes two cycles, no flags
// - Timer-mode read copies mode register, one cycle
// - File XOR combines accumulator and register, one cycle
// - Destination bit selects accumulator or register
// - Immediate XOR always writes accumulator
`timescale 1ns/10ps
`include "trx_params.svh"

module trx_exec
  import trx_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic op_valid,
  input wire trx_op_t op_code,
  input wire logic [`TRX_DW-1:0] op_operand,
  input wire logic op_dest,
  input wire logic [`TRX_DW-1:0] table_pointer_high,
  input wire logic [`TRX_DW-1:0] timer0_mode_reg,
  input wire logic [`TRX_DW-1:0] file_rdata,
  input wire logic [`TRX_ROM_W-1:0] rom_rdata,
  output logic [`TRX_DW-1:0] working_register_q,
  output logic [`TRX_DW-1:0] table_data_high_q,
  output logic [`TRX_ROM_AW-1:0] rom_addr_q,
  output logic rom_rd_q,
  output logic [`TRX_FA_W-1:0] file_addr_q,
  output logic [`TRX_DW-1:0] file_wdata_q,
  output logic file_we_q,
  output logic zero_flag_q,
  output logic zero_update_q
);

  trx_state_t state_q;
  logic accept;
  logic is_table;
  logic is_timer;
  logic is_xfile;
  logic is_ximm;
  logic [`TRX_DW-1:0] xor_operand;
  logic [`TRX_DW-1:0] xor_result;
  logic xor_zero;

  // Ops are taken only while no table fetch is pending
  assign accept = op_valid && (state_q == trx_st_idle);
  assign is_table = accept && (op_code == trx_op_table_read);
  assign is_timer = accept && (op_code == trx_op_read_timer);
  assign is_xfile = accept && (op_code == trx_op_xor_file);
  assign is_ximm = accept && (op_code == trx_op_xor_imm);
  assign xor_operand = (op_code == trx_op_xor_file) ? file_rdata : op_operand;

  trx_xor_unit u_xor (
    .a(working_register_q),
    .b(xor_operand),
    .result(xor_result),
    .is_zero(xor_zero)
  );

  // Sequencer: table read spends a second cycle fetching
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= trx_st_idle;
    end else begin
      case (state_q)
        trx_st_idle: begin
          if (is_table) begin
            state_q <= trx_st_fetch;
          end
        end
        trx_st_fetch: begin
          state_q <= trx_st_idle;
        end
        default: begin
          state_q <= trx_st_idle;
        end
      endcase
    end
  end

  // Program memory request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rom_addr_q <= `TRX_ROM_ADDR_RST;
      rom_rd_q <= 1'b0;
    end else begin
      rom_rd_q <= is_table;
      if (is_table) begin
        rom_addr_q <= {table_pointer_high[`TRX_PTR_BITS-1:0], working_register_q};
      end
    end
  end

  // Accumulator
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      working_register_q <= `TRX_BYTE_RST;
    end else if (state_q == trx_st_fetch) begin
      working_register_q <= rom_rdata[`TRX_DW-1:0];
    end else if (is_timer) begin
      working_register_q <= timer0_mode_reg;
    end else if ((is_xfile && !op_dest) || is_ximm) begin
      working_register_q <= xor_result;
    end
  end

  // Table data high
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      table_data_high_q <= `TRX_BYTE_RST;
    end else if (state_q == trx_st_fetch) begin
      table_data_high_q <= {{(`TRX_DW-`TRX_HI_BITS){1'b0}}, rom_rdata[`TRX_ROM_W-1:`TRX_HI_LSB]};
    end
  end

  // File write-back
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      file_we_q <= 1'b0;
      file_addr_q <= `TRX_FA_RST;
      file_wdata_q <= `TRX_BYTE_RST;
    end else begin
      file_we_q <= is_xfile && op_dest;
      if (is_xfile) begin
        file_addr_q <= op_operand[`TRX_FA_W-1:0];
        file_wdata_q <= xor_result;
      end
    end
  end

  // Zero flag; carry flags are never touched here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      zero_flag_q <= 1'b0;
      zero_update_q <= 1'b0;
    end else begin
      zero_update_q <= is_xfile || is_ximm;
      if (is_xfile || is_ximm) begin
        zero_flag_q <= xor_zero;
      end
    end
  end

  property p_rom_addr;
    @(posedge clock) disable iff (!arst_n)
    is_table |=> rom_rd_q && (rom_addr_q[`TRX_DW-1:0] == $past(working_register_q))
      && (rom_addr_q[`TRX_ROM_AW-1:`TRX_DW] == $past(table_pointer_high[`TRX_PTR_BITS-1:0]));
  endproperty
  a_rom_addr: assert property (p_rom_addr) else $error("Table address not formed from pointer and accumulator");

  property p_acc_load;
    @(posedge clock) disable iff (!arst_n)
    rom_rd_q |=> working_register_q == $past(rom_rdata[`TRX_DW-1:0]);
  endproperty
  a_acc_load: assert property (p_acc_load) else $error("Accumulator missed low ROM byte");

  property p_tdh_load;
    @(posedge clock) disable iff (!arst_n)
    rom_rd_q |=> table_data_high_q == {{(`TRX_DW-`TRX_HI_BITS){1'b0}}, $past(rom_rdata[`TRX_ROM_W-1:`TRX_HI_LSB])};
  endproperty
  a_tdh_load: assert property (p_tdh_load) else $error("Table data high not loaded from upper bits");

  property p_two_cycle;
    @(posedge clock) disable iff (!arst_n)
    is_table |=> rom_rd_q && !accept && !zero_update_q ##1 !rom_rd_q && !zero_update_q && !file_we_q;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("Table read not two cycles or touched flags");

  property p_timer;
    @(posedge clock) disable iff (!arst_n)
    is_timer |=> (working_register_q == $past(timer0_mode_reg)) && !zero_update_q;
  endproperty
  a_timer: assert property (p_timer) else $error("Timer mode copy wrong");

  property p_xfile_wr;
    @(posedge clock) disable iff (!arst_n)
    is_xfile && op_dest |=> file_we_q && (file_wdata_q == ($past(working_register_q) ^ $past(file_rdata)))
      && (file_addr_q == $past(op_operand[`TRX_FA_W-1:0])) && $stable(working_register_q);
  endproperty
  a_xfile_wr: assert property (p_xfile_wr) else $error("File XOR write-back wrong");

  property p_xfile_acc;
    @(posedge clock) disable iff (!arst_n)
    is_xfile && !op_dest |=> !file_we_q && (working_register_q == ($past(working_register_q) ^ $past(file_rdata)));
  endproperty
  a_xfile_acc: assert property (p_xfile_acc) else $error("File XOR to accumulator wrong");

  property p_ximm;
    @(posedge clock) disable iff (!arst_n)
    is_ximm |=> !file_we_q && (working_register_q == ($past(working_register_q) ^ $past(op_operand)));
  endproperty
  a_ximm: assert property (p_ximm) else $error("Immediate XOR wrong");

  property p_zero;
    @(posedge clock) disable iff (!arst_n)
    zero_update_q |-> zero_flag_q == ($past(working_register_q ^ ((op_code == trx_op_xor_file) ? file_rdata : op_operand))
      == `TRX_BYTE_RST);
  endproperty
  a_zero: assert property (p_zero) else $error("Zero flag does not match XOR result");

  property p_rd_pulse;
    @(posedge clock) disable iff (!arst_n)
    rom_rd_q |=> !rom_rd_q;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("Table fetch longer than one cycle");

  property p_tdh_hold;
    @(posedge clock) disable iff (!arst_n)
    !rom_rd_q |=> $stable(table_data_high_q);
  endproperty
  a_tdh_hold: assert property (p_tdh_hold) else $error("Table data high changed outside a table read");

  property p_zero_hold;
    @(posedge clock) disable iff (!arst_n)
    !(is_xfile || is_ximm) |=> $stable(zero_flag_q) && !zero_update_q;
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("Zero flag changed without an XOR");

endmodule : trx_exec

// ===== verilog/trx_params.svh
/*
  Widths, field positions and reset values for the table-read and XOR execution unit.
  Assumes it is included by the design modules and by the testbench.
*/
`ifndef TRX_PARAMS_SVH
`define TRX_PARAMS_SVH

`define TRX_DW 8
`define TRX_ROM_W 14
`define TRX_ROM_AW 11
`define TRX_PTR_BITS 3
`define TRX_HI_BITS 6
`define TRX_HI_LSB 8
`define TRX_FA_W 7
`define TRX_BYTE_RST 8'h00
`define TRX_ROM_ADDR_RST 11'h000
`define TRX_FA_RST 7'h00

`endif

// ===== verilog/trx_pkg.sv
/*
  Types shared by the execution unit: operation select and sequencer states.
  Assumes the decoder drives an operation code of type trx_op_t.
*/
package trx_pkg;

  typedef enum logic [2:0] {
    trx_op_none,
    trx_op_table_read,
    trx_op_read_timer,
    trx_op_xor_file,
    trx_op_xor_imm
  } trx_op_t;

  typedef enum logic {
    trx_st_idle,
    trx_st_fetch
  } trx_state_t;

endpackage : trx_pkg

// ===== verilog/trx_xor_unit.sv
/*
  Combinational exclusive-OR of the working register with an operand, plus a zero test.
  Assumes the caller registers the results.
*/
`timescale 1ns/10ps
`include "trx_params.svh"

module trx_xor_unit (
  input wire logic [`TRX_DW-1:0] a,
  input wire logic [`TRX_DW-1:0] b,
  output logic [`TRX_DW-1:0] result,
  output logic is_zero
);

  always_comb begin
    result = a ^ b;
    is_zero = ((a ^ b) == `TRX_BYTE_RST);
  end

endmodule : trx_xor_unit
